// >>> hw/eir_pin_if.sv
// Interface: synchronised pin events from the pin stage to the core
`timescale 1ns/1ns
interface eir_pin_if;
    import eir_pkg::*;
    logic [N_EXT-1:0] ext_fall;
    logic nmi_fall;
    logic shared_lvl;
    logic dev_rst_n;
    modport sync (output ext_fall, nmi_fall, shared_lvl, dev_rst_n);
    modport core (input ext_fall, nmi_fall, shared_lvl, dev_rst_n);
endinterface : eir_pin_if

// >>> hw/eir_pin_sync.sv
// Two-stage synchronisers and falling-edge detectors for the pins
`timescale 1ns/1ns
module eir_pin_sync
    import eir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Raw pins
    input wire logic [N_EXT-1:0] ext_irq_n_i,
    input wire logic shared_pin_i,
    input wire logic dev_reset_n_i,
    // Core side
    eir_pin_if.sync pins
);
    localparam int W = N_EXT + 2;
    localparam logic [W-1:0] SYNC_RST = {W{1'b1}};

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // ------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------
    // Idle-high reset value avoids a false edge after reset
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta <= SYNC_RST;
            stable <= SYNC_RST;
            prev <= SYNC_RST;
        end else begin
            meta <= {dev_reset_n_i, shared_pin_i, ext_irq_n_i};
            stable <= meta;
            prev <= stable;
        end
    end

    // Edge detect looks only at the second stage and its copy
    assign pins.ext_fall = prev[N_EXT-1:0] & ~stable[N_EXT-1:0];
    assign pins.nmi_fall = prev[N_EXT] & ~stable[N_EXT];
    assign pins.shared_lvl = stable[N_EXT];
    assign pins.dev_rst_n = stable[N_EXT+1];
endmodule : eir_pin_sync

// >>> hw/eir_pkg.sv
// Package: constants, register map and types of the interrupt/reset block
package eir_pkg;
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int N_EXT = 4;
    localparam int EXT_LO_W = 2;
    localparam int EV_W = 3;
    localparam int FADDR_W = 24;
    localparam int VNUM_W = 5;
    localparam int DEC_W = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_ENA_LO = 8'h00;
    localparam logic [7:0] OFF_ENA_HI = 8'h04;
    localparam logic [7:0] OFF_FLAG_LO = 8'h08;
    localparam logic [7:0] OFF_FLAG_HI = 8'h0C;
    localparam logic [7:0] OFF_STATUS1 = 8'h10;
    localparam logic [7:0] OFF_SIG_SEL = 8'h14;
    localparam logic [7:0] OFF_VPTR = 8'h18;
    localparam logic [7:0] OFF_EV_STAT = 8'h1C;
    localparam logic [7:0] OFF_EV_MASK = 8'h20;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int STAT_GMASK_BIT = 0;
    localparam int SEL_WDT_BIT = 0;
    localparam int EV_EXT = 0;
    localparam int EV_NMI = 1;
    localparam int EV_FETCH = 2;
    localparam logic GMASK_RST = 1'b1;
    localparam logic [15:0] VP_RST = 16'hFFFF;
    localparam logic [23:0] RESET_VEC_ADDR = 24'hFF_FF00;
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_NMI = 5'h01;
    localparam logic [4:0] VEC_EXT0 = 5'h02;
    localparam logic [2:0] VEC_LSB = 3'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_FETCH = 2'b01,
        ST_RUN = 2'b10
    } eir_state_t;

    // Vector location: pointer, slot number, eight bytes per slot
    function automatic logic [23:0] eir_vec_addr(input logic [15:0] vp,
                                                input logic [4:0] num);
        eir_vec_addr = {vp, num, VEC_LSB};
    endfunction : eir_vec_addr
endpackage : eir_pkg

// >>> hw/eir_top.sv
// Top: external interrupt, shared NMI/watchdog pin and device reset logic
`timescale 1ns/1ns
// Function
// - Four maskable inputs, each gated by an enable bit over two registers
// - One global mask bit blocks all maskable interrupts together
// - Pending flags readable for polling, cleared by software write
// - Select register picks shared pin role; NMI after reset
// - NMI always taken, never blocked by any enable bit
// - In watchdog role the shared pin is both input and output
// - Acknowledge output asserted while an accepted vector is fetched
// - Acknowledge output is one while the device is held in reset
// - Device reset input stops program execution
// - On reset release fetch reset vector FFFF00h from pointer FFFFh
module eir_top
    import eir_pkg::*;
#(
    parameter int NUM_EXT = N_EXT
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Device pins
    input wire logic [NUM_EXT-1:0] ext_irq_n_i,
    input wire logic dev_reset_n_i,
    input wire logic watchdog_pin_i,
    output logic watchdog_pin_o,
    output logic watchdog_pin_oe_o,
    output logic irq_ack_out_n_o,
    // Watchdog timer side
    input wire logic wdt_drive_i,
    output logic wdt_sense_o,
    // CPU core side
    input wire logic cpu_accept_i,
    input wire logic cpu_fetch_done_i,
    output logic cpu_halt_o,
    output logic fetch_req_o,
    output logic [FADDR_W-1:0] fetch_addr_o,
    // Interrupt to system
    output logic irq_o
);
    eir_pin_if pins ();

    eir_state_t state;
    eir_state_t next_state;
    logic [N_EXT-1:0] enable;
    logic [N_EXT-1:0] flag;
    logic [N_EXT-1:0] next_flag;
    logic global_irq_mask;
    logic sel_wdt_role;
    logic [15:0] vector_pointer;
    logic nmi_pend;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    logic [EV_W-1:0] next_ev_stat;
    logic wr_pend;
    logic [DEC_W-1:0] wr_addr;
    logic [31:0] rd_word;
    logic [N_EXT-1:0] taken;
    logic [N_EXT-1:0] pick;
    logic [4:0] pick_num;
    logic accept;
    logic [N_EXT-1:0] acc_clr;
    logic [N_EXT-1:0] w1c_flag;
    logic [FADDR_W-1:0] next_addr;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    eir_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .ext_irq_n_i(ext_irq_n_i),
        .shared_pin_i(watchdog_pin_i),
        .dev_reset_n_i(dev_reset_n_i),
        .pins(pins.sync)
    );

    // ------------------------------------------------------------------
    // AHB-Lite decode
    // ------------------------------------------------------------------
    // Only the low byte is decoded; the window aliases above it
    wire ahb_req = hsel_i && htrans_i[1] && hready_i;
    wire [DEC_W-1:0] a_addr = haddr_i[DEC_W-1:0];
    wire w_ena_lo = wr_pend && (wr_addr == OFF_ENA_LO);
    wire w_ena_hi = wr_pend && (wr_addr == OFF_ENA_HI);
    wire w_flag_lo = wr_pend && (wr_addr == OFF_FLAG_LO);
    wire w_flag_hi = wr_pend && (wr_addr == OFF_FLAG_HI);
    wire w_status1 = wr_pend && (wr_addr == OFF_STATUS1);
    wire w_sig_sel = wr_pend && (wr_addr == OFF_SIG_SEL);
    wire w_vptr = wr_pend && (wr_addr == OFF_VPTR);
    wire w_ev_stat = wr_pend && (wr_addr == OFF_EV_STAT);
    wire w_ev_mask = wr_pend && (wr_addr == OFF_EV_MASK);
    wire [EXT_LO_W-1:0] wd_lo = hwdata_i[EXT_LO_W-1:0];
    wire [EXT_LO_W-1:0] wd_zero = '0;

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_word = '0;
        if (a_addr == OFF_ENA_LO) begin
            rd_word[EXT_LO_W-1:0] = enable[EXT_LO_W-1:0];
        end else if (a_addr == OFF_ENA_HI) begin
            rd_word[EXT_LO_W-1:0] = enable[N_EXT-1:EXT_LO_W];
        end else if (a_addr == OFF_FLAG_LO) begin
            rd_word[EXT_LO_W-1:0] = flag[EXT_LO_W-1:0];
        end else if (a_addr == OFF_FLAG_HI) begin
            rd_word[EXT_LO_W-1:0] = flag[N_EXT-1:EXT_LO_W];
        end else if (a_addr == OFF_STATUS1) begin
            rd_word[STAT_GMASK_BIT] = global_irq_mask;
        end else if (a_addr == OFF_SIG_SEL) begin
            rd_word[SEL_WDT_BIT] = sel_wdt_role;
        end else if (a_addr == OFF_VPTR) begin
            rd_word[15:0] = vector_pointer;
        end else if (a_addr == OFF_EV_STAT) begin
            rd_word[EV_W-1:0] = ev_stat;
        end else if (a_addr == OFF_EV_MASK) begin
            rd_word[EV_W-1:0] = ev_mask;
        end
    end

    // Zero wait states: data phase always completes in one cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata_o <= '0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend <= ahb_req && hwrite_i;
            wr_addr <= a_addr;
            hrdata_o <= (ahb_req && !hwrite_i) ? rd_word : '0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Device reset restores pointer, mask and pin role
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !pins.dev_rst_n) begin
            enable <= '0;
            global_irq_mask <= GMASK_RST;
            sel_wdt_role <= 1'b0;
            vector_pointer <= VP_RST;
            ev_mask <= '0;
        end else begin
            if (w_ena_lo) begin
                enable[EXT_LO_W-1:0] <= wd_lo;
            end
            if (w_ena_hi) begin
                enable[N_EXT-1:EXT_LO_W] <= wd_lo;
            end
            if (w_status1) begin
                global_irq_mask <= hwdata_i[STAT_GMASK_BIT];
            end
            if (w_sig_sel) begin
                sel_wdt_role <= hwdata_i[SEL_WDT_BIT];
            end
            if (w_vptr) begin
                vector_pointer <= hwdata_i[15:0];
            end
            if (w_ev_mask) begin
                ev_mask <= hwdata_i[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pending flags and arbitration
    // ------------------------------------------------------------------
    // A new edge wins over a clear in the same cycle
    assign w1c_flag = {w_flag_hi ? wd_lo : wd_zero,
                       w_flag_lo ? wd_lo : wd_zero};
    assign next_flag = (flag & ~(w1c_flag | acc_clr)) | pins.ext_fall;
    assign taken = flag & enable & {N_EXT{~global_irq_mask}};

    // Downward scan leaves the lowest index selected
    always_comb begin
        pick = '0;
        pick_num = VEC_EXT0;
        for (int i = N_EXT - 1; i >= 0; i--) begin
            if (taken[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                pick_num = VEC_EXT0 + 5'(i);
            end
        end
    end

    // NMI ignores every enable and the global mask
    assign accept = (state == ST_RUN) && cpu_accept_i
                    && (nmi_pend || (|taken));
    assign acc_clr = (accept && !nmi_pend) ? pick : '0;
    assign next_addr = nmi_pend ? eir_vec_addr(vector_pointer, VEC_NMI)
                                : eir_vec_addr(vector_pointer, pick_num);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            flag <= '0;
            nmi_pend <= 1'b0;
        end else begin
            flag <= next_flag;
            nmi_pend <= (nmi_pend && !accept)
                        || (pins.nmi_fall && !sel_wdt_role);
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: hold, vector fetch, run
    // ------------------------------------------------------------------
    // Device reset overrides everything, even an ongoing fetch
    always_comb begin
        next_state = state;
        if (!pins.dev_rst_n) begin
            next_state = ST_HOLD;
        end else begin
            case (state)
                ST_HOLD: next_state = ST_FETCH;
                ST_FETCH: begin
                    if (cpu_fetch_done_i) begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (accept) begin
                        next_state = ST_FETCH;
                    end
                end
                default: next_state = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state <= ST_HOLD;
            cpu_halt_o <= 1'b1;
            fetch_req_o <= 1'b0;
            fetch_addr_o <= RESET_VEC_ADDR;
            irq_ack_out_n_o <= 1'b1;
        end else begin
            state <= next_state;
            cpu_halt_o <= (next_state == ST_HOLD);
            fetch_req_o <= (next_state == ST_FETCH);
            irq_ack_out_n_o <= (next_state != ST_FETCH);
            if (state == ST_HOLD) begin
                fetch_addr_o <= RESET_VEC_ADDR;
            end else if (accept) begin
                fetch_addr_o <= next_addr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared pin, events and interrupt output
    // ------------------------------------------------------------------
    assign next_ev_stat = (ev_stat & ~(w_ev_stat ? hwdata_i[EV_W-1:0] : '0))
                          | {(state == ST_FETCH) && cpu_fetch_done_i,
                             pins.nmi_fall && !sel_wdt_role,
                             |pins.ext_fall};

    // Pin driven only in watchdog role; sense path serves the timer
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            watchdog_pin_oe_o <= 1'b0;
            watchdog_pin_o <= 1'b0;
            wdt_sense_o <= 1'b1;
            ev_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            watchdog_pin_oe_o <= sel_wdt_role;
            watchdog_pin_o <= wdt_drive_i;
            wdt_sense_o <= pins.shared_lvl;
            ev_stat <= next_ev_stat;
            irq_o <= |(next_ev_stat & ev_mask);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    property p_ack_hold;
        cpu_halt_o |-> irq_ack_out_n_o;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("ack low while held in reset");

    property p_ack_fetch;
        fetch_req_o == !irq_ack_out_n_o;
    endproperty
    a_ack_fetch: assert property (p_ack_fetch)
        else $error("ack not matching vector fetch");

    property p_halt;
        !pins.dev_rst_n |=> cpu_halt_o && !fetch_req_o;
    endproperty
    a_halt: assert property (p_halt)
        else $error("execution not stopped by device reset");

    property p_reset_vec;
        $fell(cpu_halt_o) |-> fetch_req_o && fetch_addr_o == RESET_VEC_ADDR;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset release did not fetch reset vector");

    property p_nmi_first;
        accept && nmi_pend && pins.dev_rst_n
            |=> fetch_req_o && fetch_addr_o[7:3] == VEC_NMI;
    endproperty
    a_nmi_first: assert property (p_nmi_first)
        else $error("pending NMI not fetched first");

    property p_nmi_taken;
        state == ST_RUN && nmi_pend && cpu_accept_i && pins.dev_rst_n
            |=> fetch_req_o;
    endproperty
    a_nmi_taken: assert property (p_nmi_taken)
        else $error("NMI blocked");

    property p_gmask;
        state == ST_RUN && global_irq_mask && !nmi_pend |=> !fetch_req_o;
    endproperty
    a_gmask: assert property (p_gmask)
        else $error("maskable taken under global mask");

    property p_enable;
        state == ST_RUN && !nmi_pend && (flag & enable) == '0
            |=> !fetch_req_o;
    endproperty
    a_enable: assert property (p_enable)
        else $error("disabled source taken");

    property p_low_first;
        accept && !nmi_pend && taken[0] && pins.dev_rst_n
            |=> fetch_addr_o[7:3] == VEC_EXT0;
    endproperty
    a_low_first: assert property (p_low_first)
        else $error("lowest index not chosen");

    property p_flag_set;
        pins.ext_fall[0] |=> flag[0]
            ##1 (flag[0] || $past(w_flag_lo) || $past(accept));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("falling edge did not set flag");

    property p_w1c;
        w_flag_lo && hwdata_i[0] && !pins.ext_fall[0] |=> !flag[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("flag write-one did not clear");

    property p_pin_role;
        ##1 watchdog_pin_oe_o == $past(sel_wdt_role);
    endproperty
    a_pin_role: assert property (p_pin_role)
        else $error("shared pin drive not following select");

    c_nmi: cover property (accept && nmi_pend);
    c_ext: cover property (accept && !nmi_pend ##[1:20] cpu_fetch_done_i);
    c_reset: cover property ($fell(cpu_halt_o));
    c_w1c: cover property (w_flag_hi && |hwdata_i[EXT_LO_W-1:0]);
endmodule : eir_top

// >>> testbench/eir_cpu_model.sv
// Partner model: CPU core that accepts interrupts and fetches vectors
`timescale 1ns/1ns
module eir_cpu_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Bench control
    input wire logic accept_en_i,
    input wire logic [3:0] done_dly_i,
    // Device side
    input wire logic fetch_req_i,
    output logic cpu_accept_o,
    output logic cpu_fetch_done_o
);
    logic [3:0] busy_cnt;

    // Cycles spent in the current vector fetch; slow answers stretch it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !fetch_req_i) begin
            busy_cnt <= 4'h0;
        end else if (busy_cnt != 4'hF) begin
            busy_cnt <= busy_cnt + 4'h1;
        end
    end

    // No accept offered while a fetch is still in flight
    assign cpu_accept_o = accept_en_i & ~fetch_req_i;
    assign cpu_fetch_done_o = fetch_req_i && (busy_cnt >= done_dly_i);
endmodule : eir_cpu_model

// >>> testbench/ext_interrupt_reset_pins_tb_top.sv
// Testbench: register bus, pins, priority, watchdog role and device reset
`timescale 1ns/1ns
module ext_interrupt_reset_pins_tb_top;
    import eir_pkg::*;
    logic sys_clk, rst, hsel, hwrite, dev_rst_n, nmi_drv, wdt_drv, acc_en;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0] ext_n, dly;
    logic hreadyout, hresp, pin_o, pin_oe, ack_n, sense, halt, freq, irq;
    logic accept, done;
    logic [23:0] faddr;
    wire pin_wire = pin_oe ? pin_o : nmi_drv;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    eir_top dut (.sys_clk_i(sys_clk), .reset_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .ext_irq_n_i(ext_n), .dev_reset_n_i(dev_rst_n),
        .watchdog_pin_i(pin_wire), .watchdog_pin_o(pin_o),
        .watchdog_pin_oe_o(pin_oe), .irq_ack_out_n_o(ack_n),
        .wdt_drive_i(wdt_drv), .wdt_sense_o(sense), .cpu_accept_i(accept),
        .cpu_fetch_done_i(done), .cpu_halt_o(halt), .fetch_req_o(freq),
        .fetch_addr_o(faddr), .irq_o(irq));

    eir_cpu_model cpu (.sys_clk_i(sys_clk), .reset_i(rst),
        .accept_en_i(acc_en), .done_dly_i(dly), .fetch_req_i(freq),
        .cpu_accept_o(accept), .cpu_fetch_done_o(done));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    // Single word transfer; waits on hready, never on a fixed count
    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cycles

    // Expect one vector fetch at the given address, then its end
    task automatic wait_fetch(input logic [23:0] exp);
        int i;
        i = 0;
        while (freq !== 1'b1 && i < 60) begin
            cycles(1);
            i++;
        end
        chk(faddr, exp);
        chk(ack_n, 0);
        i = 0;
        while (freq !== 1'b0 && i < 60) begin
            cycles(1);
            i++;
        end
        chk(ack_n, 1);
    endtask : wait_fetch

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_state();
        chk({halt, ack_n}, 2'b11);
        rst <= 1'b0;
        wait_fetch(24'hFF_FF00);
        ahb_xfer(1'b0, OFF_STATUS1, 0);
        chk(rd, 1);
        ahb_xfer(1'b0, OFF_SIG_SEL, 0);
        chk(rd, 0);
        ahb_xfer(1'b0, OFF_VPTR, 0);
        chk(rd, 32'h0000_FFFF);
        ahb_xfer(1'b0, 8'h40, 0);
        chk(rd, 0);
        chk({hreadyout, hresp}, 2'b10);
    endtask : test_reset_state

    // Global mask holds a pending, enabled source back
    task automatic test_mask_flags();
        ahb_xfer(1'b1, OFF_ENA_LO, 1);
        acc_en <= 1'b1;
        ext_n[0] <= 1'b0;
        cycles(6);
        chk(freq, 0);
        ahb_xfer(1'b0, OFF_FLAG_LO, 0);
        chk(rd, 1);
        ahb_xfer(1'b1, OFF_STATUS1, 0);
        wait_fetch(24'hFF_FF10);
        ahb_xfer(1'b0, OFF_FLAG_LO, 0);
        chk(rd, 0);
        acc_en <= 1'b0;
        ext_n <= 4'b1100;
        cycles(6);
        ahb_xfer(1'b0, OFF_FLAG_LO, 0);
        chk(rd, 2);
        ahb_xfer(1'b1, OFF_FLAG_LO, 2);
        ahb_xfer(1'b0, OFF_FLAG_LO, 0);
        chk(rd, 0);
        ext_n <= 4'hF;
    endtask : test_mask_flags

    // NMI ignores masks; simultaneous sources resolve by priority
    task automatic test_priority();
        dly <= 4'h5;
        ahb_xfer(1'b1, OFF_STATUS1, 1);
        ahb_xfer(1'b1, OFF_ENA_LO, 0);
        nmi_drv <= 1'b0;
        acc_en <= 1'b1;
        wait_fetch(24'hFF_FF08);
        acc_en <= 1'b0;
        nmi_drv <= 1'b1;
        ahb_xfer(1'b1, OFF_ENA_LO, 3);
        ahb_xfer(1'b1, OFF_ENA_HI, 1);
        ahb_xfer(1'b1, OFF_STATUS1, 0);
        ext_n <= 4'b0001;
        nmi_drv <= 1'b0;
        cycles(6);
        acc_en <= 1'b1;
        wait_fetch(24'hFF_FF08);
        wait_fetch(24'hFF_FF18);
        wait_fetch(24'hFF_FF20);
        // Input 3 fell too but stays disabled: pending, never fetched
        cycles(4);
        chk(freq, 0);
        ahb_xfer(1'b0, OFF_FLAG_HI, 0);
        chk(rd, 2);
        ahb_xfer(1'b1, OFF_FLAG_HI, 2);
        ahb_xfer(1'b0, OFF_FLAG_HI, 0);
        chk(rd, 0);
        acc_en <= 1'b0;
        ext_n <= 4'hF;
        nmi_drv <= 1'b1;
        dly <= 4'h1;
    endtask : test_priority

    // Sticky event bits, mask and W1C drive the level interrupt
    task automatic test_events();
        chk(irq, 0);
        ahb_xfer(1'b0, OFF_EV_STAT, 0);
        chk(rd, 7);
        ahb_xfer(1'b1, OFF_EV_MASK, 4);
        cycles(2);
        chk(irq, 1);
        ahb_xfer(1'b1, OFF_EV_STAT, 7);
        cycles(2);
        chk(irq, 0);
    endtask : test_events

    // Watchdog role: pin driven out and sensed back
    task automatic test_watchdog();
        wdt_drv <= 1'b0;
        ahb_xfer(1'b1, OFF_SIG_SEL, 1);
        cycles(5);
        chk({pin_oe, pin_o, sense}, 3'b100);
        wdt_drv <= 1'b1;
        cycles(5);
        chk({pin_oe, pin_o, sense}, 3'b111);
        ahb_xfer(1'b1, OFF_SIG_SEL, 0);
        cycles(2);
        chk(pin_oe, 0);
    endtask : test_watchdog

    // Device reset stops execution and restarts at the reset vector
    task automatic test_dev_reset();
        ahb_xfer(1'b1, OFF_VPTR, 32'h0000_1234);
        dev_rst_n <= 1'b0;
        cycles(5);
        chk({halt, ack_n, freq}, 3'b110);
        ahb_xfer(1'b0, OFF_VPTR, 0);
        chk(rd, 32'h0000_FFFF);
        dev_rst_n <= 1'b1;
        wait_fetch(24'hFF_FF00);
        chk(halt, 0);
    endtask : test_dev_reset

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        ext_n = 4'hF;
        dev_rst_n = 1'b1;
        nmi_drv = 1'b1;
        wdt_drv = 1'b0;
        acc_en = 1'b0;
        dly = 4'h1;
        cycles(20);
        test_reset_state();
        test_mask_flags();
        test_priority();
        test_events();
        test_watchdog();
        test_dev_reset();
        finish_test();
    end
endmodule : ext_interrupt_reset_pins_tb_top
